// [dv/ccv_top_tb_top.sv]
/*
 Self-checking testbench of the capture/compare value register block.
 Assumes the design package and ccv_top are compiled first; drives APB and timer inputs.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t ns: got %0h want %0h", $time, got, exp); end end
module ccv_top_tb_top;
    import ccv_pkg::*;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [VAL_W-1:0]  counter_value;
    logic [1:0]        capture_event;
    logic              update_event;
    logic [VAL_W-1:0]  compare_value0;
    logic [VAL_W-1:0]  compare_value1;
    logic [1:0]        chan_input_mode;
    int                errors;
    int                n_checks;

    ccv_top i_dut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .pstrb           (pstrb),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .counter_value   (counter_value),
        .capture_event   (capture_event),
        .update_event    (update_event),
        .compare_value0  (compare_value0),
        .compare_value1  (compare_value1),
        .chan_input_mode (chan_input_mode)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic is_wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s,
                        output logic [DATA_W-1:0] rdat, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [STRB_W-1:0] s, input logic eerr);
        logic [DATA_W-1:0] rdat;
        logic              err;
        xfer(1'b1, a, d, s, rdat, err);
        `CHK(err, eerr)
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                      input logic eerr);
        logic [DATA_W-1:0] rdat;
        logic              err;
        xfer(1'b0, a, 32'h00000000, 4'h0, rdat, err);
        `CHK(err, eerr)
        `CHK(rdat, exp)
    endtask

    // Timer event pulse of one cycle with a counter value
    task automatic pulse(input logic [1:0] cap, input logic upd, input logic [VAL_W-1:0] cnt);
        @(posedge pclk);
        capture_event <= cap;
        update_event  <= upd;
        counter_value <= cnt;
        @(posedge pclk);
        capture_event <= 2'h0;
        update_event  <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        rd(OFF_CH0, 32'h00000000, 1'b0);
        rd(OFF_CH1, 32'h00000000, 1'b0);
        rd(OFF_CFG, 32'h00000000, 1'b0);
        `CHK(compare_value0, 16'h0000)
    endtask

    task automatic t_cfg();
        wr(OFF_CFG, 32'h00000002, 4'hF, 1'b0);
        rd(OFF_CFG, 32'h00000002, 1'b0);
        wr(OFF_CFG, 32'h00000000, 4'hF, 1'b0);
        rd(OFF_CFG, 32'h00000000, 1'b0);
    endtask

    task automatic t_out();
        wr(OFF_CH0, 32'h00001234, 4'hF, 1'b0);
        rd(OFF_CH0, 32'h00001234, 1'b0);
        `CHK(compare_value0, 16'h1234)
        wr(OFF_CH1, 32'hFFFFABCD, STRB_HALF, 1'b0);
        rd(OFF_CH1, 32'h0000ABCD, 1'b0);
        `CHK(compare_value1, 16'hABCD)
    endtask

    task automatic t_shadow();
        wr(OFF_MODE, 32'h00000202, 4'hF, 1'b0);
        wr(OFF_CH0, 32'h00005555, 4'hF, 1'b0);
        wr(OFF_CH1, 32'h00006666, STRB_HALF, 1'b0);
        `CHK(compare_value0, 16'h1234)
        `CHK(compare_value1, 16'hABCD)
        pulse(2'h0, 1'b1, 16'h0000);
        `CHK(compare_value0, 16'h5555)
        `CHK(compare_value1, 16'h6666)
        pulse(2'h3, 1'b0, 16'h0F0F);
        rd(OFF_CH0, 32'h00005555, 1'b0);
    endtask

    task automatic t_input();
        wr(OFF_MODE, 32'h00000101, 4'hF, 1'b0);
        `CHK(chan_input_mode, 2'h3)
        pulse(2'h1, 1'b0, 16'h0F0F);
        rd(OFF_CH0, 32'h00000F0F, 1'b0);
        rd(OFF_CH1, 32'h00006666, 1'b0);
        pulse(2'h2, 1'b0, 16'h7070);
        rd(OFF_CH1, 32'h00007070, 1'b0);
        wr(OFF_CH0, 32'h00001111, 4'hF, 1'b0);
        rd(OFF_CH0, 32'h00000F0F, 1'b0);
        wr(OFF_CH1, 32'h00002222, STRB_HALF, 1'b0);
        rd(OFF_CH1, 32'h00007070, 1'b0);
    endtask

    task automatic t_filter();
        wr(OFF_MODE, 32'h00000000, 4'hF, 1'b0);
        wr(OFF_CFG, 32'h00000002, 4'hF, 1'b0);
        wr(OFF_CH0, 32'h00000AAA, 4'hF, 1'b0);
        `CHK(compare_value0, 16'h0AAA)
        wr(OFF_MODE, 32'h00000002, 4'hF, 1'b0);
        wr(OFF_CH0, 32'h00000BBB, 4'hF, 1'b0);
        wr(OFF_MODE, 32'h00000000, 4'hF, 1'b0);
        wr(OFF_CH0, 32'h00000BBB, 4'hF, 1'b0);
        `CHK(compare_value0, 16'h0AAA)
        wr(OFF_CH1, 32'h00007070, 4'hF, 1'b0);
        `CHK(compare_value1, 16'h6666)
        wr(OFF_CFG, 32'h00000000, 4'hF, 1'b0);
        wr(OFF_CH0, 32'hFFFF0BBB, STRB_HALF, 1'b0);
        `CHK(compare_value0, 16'h0BBB)
    endtask

    task automatic t_err();
        wr(12'h040, 32'h00001111, 4'hF, 1'b1);
        rd(12'h040, 32'h00000000, 1'b1);
        wr(12'h036, 32'h00001111, 4'hF, 1'b1);
        rd(OFF_CH0, 32'h00000BBB, 1'b0);
        wr(OFF_CH0, 32'h0000EECC, 4'h1, 1'b0);
        rd(OFF_CH0, 32'h00000BCC, 1'b0);
    endtask

    task automatic print_verdict();
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        errors++;
        print_verdict();
    end

    initial begin
        errors = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        counter_value = 16'h0000;
        capture_event = 2'h0;
        update_event = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cfg();
        t_out();
        t_shadow();
        t_input();
        t_filter();
        t_err();
        print_verdict();
    end
endmodule

// [logic/ccv_chan.sv]
/*
 One capture/compare channel value: captured or written value plus active compare copy.
 Assumes capture, update and counter come from logic on the same clock.
*/
`timescale 1ns/10ps
module ccv_chan #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Configuration
    input  wire logic         input_mode,
    input  wire logic         shadow_en,
    input  wire logic         filter_en,
    // Software write
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // Timer events
    input  wire logic [W-1:0] counter,
    input  wire logic         capture,
    input  wire logic         update,
    // Values
    output logic      [W-1:0] value_r,
    output logic      [W-1:0] active_r
);
    import ccv_pkg::*;

    logic wr_take;

    // Write accepted in output mode unless same-value filter drops it
    assign wr_take = wr_en && !input_mode && !(filter_en && (wr_data == value_r));

    // Visible value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_r <= RST_VAL;
        end else if (input_mode) begin
            if (capture) begin
                value_r <= counter;
            end
        end else if (wr_take) begin
            value_r <= wr_data;
        end
    end

    // Active compare copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= RST_VAL;
        end else if (!input_mode) begin
            if (shadow_en) begin
                if (update) begin
                    active_r <= value_r;
                end
            end else if (wr_take) begin
                active_r <= wr_data;
            end
        end
    end

endmodule

// [logic/ccv_lane_merge.sv]
/*
 Byte-lane merge of bus write data into a register's old contents.
 Assumes strobes already qualified by the caller.
*/
`timescale 1ns/10ps
module ccv_lane_merge #(
    parameter int W = 16
) (
    // Data
    input  wire logic [W-1:0]   old_val,
    input  wire logic [W-1:0]   new_val,
    // Lane enables
    input  wire logic [W/8-1:0] lane_en,
    // Result
    output logic      [W-1:0]   merged
);

    genvar g;
    generate
        for (g = 0; g < W / 8; g++) begin : g_lane
            assign merged[g*8 +: 8] = lane_en[g] ? new_val[g*8 +: 8] : old_val[g*8 +: 8];
        end
    endgenerate

endmodule

// [logic/ccv_pkg.sv]
/*
 Shared constants of the capture/compare value register block:
 register offsets, field positions, reset values and bus state codes.
 Assumes a 12-bit APB byte address and 32-bit APB data.
*/
package ccv_pkg;

    // Bus and data widths
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int VAL_W     = 16;
    localparam int STRB_W    = DATA_W / 8;
    localparam int VSTRB_W   = VAL_W / 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CH0  = 12'h034;
    localparam logic [ADDR_W-1:0] OFF_CH1  = 12'h038;
    localparam logic [ADDR_W-1:0] OFF_MODE = 12'h080;
    localparam logic [ADDR_W-1:0] OFF_CFG  = 12'h0FC;

    // Reset values
    localparam logic [VAL_W-1:0]  RST_VAL  = 16'h0000;
    localparam logic [VAL_W-1:0]  RST_CFG  = 16'h0000;
    localparam logic [VAL_W-1:0]  RST_MODE = 16'h0000;
    localparam logic [DATA_W-1:0] RD_ZERO  = 32'h00000000;
    localparam logic [VAL_W-1:0]  HI_ZERO  = 16'h0000;

    // Field positions
    localparam int CFG_FILT_BIT = 1;
    localparam int MODE_IN0_BIT = 0;
    localparam int MODE_SH0_BIT = 1;
    localparam int MODE_IN1_BIT = 8;
    localparam int MODE_SH1_BIT = 9;

    // Strobe pattern of a low half-word access
    localparam logic [STRB_W-1:0] STRB_HALF = 4'h3;

    // Bus slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } ccv_bus_state_t;

endpackage

// [logic/ccv_top.sv]
/*
 Capture/compare value registers of a timer with an APB slave port.
 Holds two channel value registers, the same-value write filter and a
 channel mode register. Assumes counter, capture and update come from
 timer logic on pclk; APB master follows the usual setup/access phases.
*/
// The implementer's own choice: the APB interface to the registers.
// Operation
// - Channel 0 in input mode reads the counter caught at the last capture and is read-only.
// - Channel 0 in output mode holds the value compared against the counter.
// - With the shadow copy on, the written value reaches the active compare only at update.
// - Channel 1 in input mode reads the counter caught at the last capture and refuses writes.
// - Channel 1 in output mode supplies the value compared against the counter.
// - With the filter bit at position 1 set, a write equal to the current value is ignored.
// - The filter bit is read and written by software, which alone changes it.
// - The channel value registers accept half-word and word accesses.
// - Both channel values and the configuration register reset to zero.
`timescale 1ns/10ps
module ccv_top (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ccv_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [ccv_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [ccv_pkg::STRB_W-1:0]    pstrb,
    output logic      [ccv_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Timer side
    input  wire logic [ccv_pkg::VAL_W-1:0]     counter_value,
    input  wire logic [1:0]                    capture_event,
    input  wire logic                          update_event,
    // Compare values and modes
    output logic      [ccv_pkg::VAL_W-1:0]     compare_value0,
    output logic      [ccv_pkg::VAL_W-1:0]     compare_value1,
    output logic      [1:0]                    chan_input_mode
);
    import ccv_pkg::*;

    ccv_bus_state_t    state_r;
    ccv_bus_state_t    state_nxt;
    logic              pready_r;
    logic              pslverr_r;
    logic [DATA_W-1:0] prdata_r;
    logic [VAL_W-1:0]  mode_r;
    logic              filt_r;
    logic [VAL_W-1:0]  chan0_value;
    logic [VAL_W-1:0]  chan1_value;
    logic [VAL_W-1:0]  chan0_active;
    logic [VAL_W-1:0]  chan1_active;
    logic              sel_ch0;
    logic              sel_ch1;
    logic              sel_cfg;
    logic              sel_mode;
    logic              addr_ok;
    logic              access_go;
    logic              wr_commit;
    logic [VAL_W-1:0]  old_sel;
    logic [VAL_W-1:0]  merged;
    logic [VAL_W-1:0]  cfg_view;
    logic [DATA_W-1:0] rd_mux;

    // Address decode on aligned words
    assign sel_ch0  = (paddr[ADDR_W-1:2] == OFF_CH0[ADDR_W-1:2]);
    assign sel_ch1  = (paddr[ADDR_W-1:2] == OFF_CH1[ADDR_W-1:2]);
    assign sel_cfg  = (paddr[ADDR_W-1:2] == OFF_CFG[ADDR_W-1:2]);
    assign sel_mode = (paddr[ADDR_W-1:2] == OFF_MODE[ADDR_W-1:2]);
    assign addr_ok  = (sel_ch0 || sel_ch1 || sel_cfg || sel_mode) && (paddr[1:0] == 2'h0);

    // Bus handshake
    assign access_go = psel && penable && (state_r == ST_WAIT);
    assign wr_commit = psel && penable && pready_r && pwrite && !pslverr_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (psel && !penable) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (psel && penable) begin
                    state_nxt = ST_DONE;
                end else if (!psel) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DONE: begin
                if (psel && !penable) begin
                    state_nxt = ST_WAIT;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= access_go;
            pslverr_r <= access_go && !addr_ok;
        end
    end

    // Read data
    assign cfg_view = {{(VAL_W-CFG_FILT_BIT-1){1'b0}}, filt_r, {CFG_FILT_BIT{1'b0}}};

    always_comb begin
        rd_mux = RD_ZERO;
        if (sel_ch0) begin
            rd_mux = {HI_ZERO, chan0_value};
        end else if (sel_ch1) begin
            rd_mux = {HI_ZERO, chan1_value};
        end else if (sel_cfg) begin
            rd_mux = {HI_ZERO, cfg_view};
        end else if (sel_mode) begin
            rd_mux = {HI_ZERO, mode_r};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= RD_ZERO;
        end else if (access_go && !pwrite && addr_ok) begin
            prdata_r <= rd_mux;
        end else if (access_go) begin
            prdata_r <= RD_ZERO;
        end
    end

    // Write data merge, upper half-word reserved
    always_comb begin
        old_sel = RST_VAL;
        if (sel_ch0) begin
            old_sel = chan0_value;
        end else if (sel_ch1) begin
            old_sel = chan1_value;
        end else if (sel_cfg) begin
            old_sel = cfg_view;
        end else if (sel_mode) begin
            old_sel = mode_r;
        end
    end

    ccv_lane_merge #(
        .W       (VAL_W)
    ) u_merge (
        .old_val (old_sel),
        .new_val (pwdata[VAL_W-1:0]),
        .lane_en (pstrb[VSTRB_W-1:0]),
        .merged  (merged)
    );

    // Configuration and mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= RST_CFG[CFG_FILT_BIT];
        end else if (wr_commit && sel_cfg) begin
            filt_r <= merged[CFG_FILT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= RST_MODE;
        end else if (wr_commit && sel_mode) begin
            mode_r <= merged;
        end
    end

    // Channels
    ccv_chan #(
        .W          (VAL_W)
    ) u_chan0 (
        .pclk       (pclk),
        .presetn    (presetn),
        .input_mode (mode_r[MODE_IN0_BIT]),
        .shadow_en  (mode_r[MODE_SH0_BIT]),
        .filter_en  (filt_r),
        .wr_en      (wr_commit && sel_ch0),
        .wr_data    (merged),
        .counter    (counter_value),
        .capture    (capture_event[0]),
        .update     (update_event),
        .value_r    (chan0_value),
        .active_r   (chan0_active)
    );

    ccv_chan #(
        .W          (VAL_W)
    ) u_chan1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .input_mode (mode_r[MODE_IN1_BIT]),
        .shadow_en  (mode_r[MODE_SH1_BIT]),
        .filter_en  (filt_r),
        .wr_en      (wr_commit && sel_ch1),
        .wr_data    (merged),
        .counter    (counter_value),
        .capture    (capture_event[1]),
        .update     (update_event),
        .value_r    (chan1_value),
        .active_r   (chan1_active)
    );

    // Outputs
    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign compare_value0  = chan0_active;
    assign compare_value1  = chan1_active;
    assign chan_input_mode = {mode_r[MODE_IN1_BIT], mode_r[MODE_IN0_BIT]};

    // Checks
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && !pready_r;
    endsequence

    sequence s_ch0_wr;
        wr_commit && sel_ch0;
    endsequence

    sequence s_ch1_wr;
        wr_commit && sel_ch1;
    endsequence

    a_bus_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_access |=> pready_r ##1 !pready_r)
        else $error("pready not raised after one wait cycle");

    a_ch0_capture_load: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[MODE_IN0_BIT] && capture_event[0] |=> chan0_value == $past(counter_value))
        else $error("channel 0 capture value wrong");

    a_ch0_write_block: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch0_wr and (mode_r[MODE_IN0_BIT] && !capture_event[0]) |=> $stable(chan0_value))
        else $error("channel 0 written in input mode");

    a_ch0_direct_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch0_wr and (!mode_r[MODE_IN0_BIT] && !mode_r[MODE_SH0_BIT] && !filt_r)
        |=> compare_value0 == $past(merged) && chan0_value == $past(merged))
        else $error("channel 0 compare value not written");

    a_shadow_update: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_r[MODE_IN0_BIT] && mode_r[MODE_SH0_BIT] && update_event
        |=> compare_value0 == $past(chan0_value))
        else $error("shadow not loaded at update");

    a_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[MODE_SH0_BIT] && !update_event && $stable(mode_r) |=> $stable(compare_value0))
        else $error("shadow active copy changed without update");

    a_ch0_shadow_defer: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch0_wr and (!mode_r[MODE_IN0_BIT] && mode_r[MODE_SH0_BIT] && !update_event)
        |=> $stable(compare_value0))
        else $error("channel 0 shadowed write reached compare early");

    a_ch1_shadow_update: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_r[MODE_IN1_BIT] && mode_r[MODE_SH1_BIT] && update_event
        |=> compare_value1 == $past(chan1_value))
        else $error("channel 1 shadow not loaded at update");

    a_ch0_input_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[MODE_IN0_BIT] |=> $stable(compare_value0))
        else $error("channel 0 compare copy moved in input mode");

    a_ch1_capture_load: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[MODE_IN1_BIT] && capture_event[1] |=> chan1_value == $past(counter_value))
        else $error("channel 1 capture value wrong");

    a_ch1_write_block: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch1_wr and (mode_r[MODE_IN1_BIT] && !capture_event[1])
        |=> $stable(chan1_value))
        else $error("channel 1 written in input mode");

    a_ch1_direct_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch1_wr and (!mode_r[MODE_IN1_BIT] && !mode_r[MODE_SH1_BIT] && !filt_r)
        |=> compare_value1 == $past(merged))
        else $error("channel 1 compare value not written");

    a_filter_same: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch0_wr and (filt_r && !mode_r[MODE_IN0_BIT] && !mode_r[MODE_SH0_BIT]
        && merged == chan0_value) |=> $stable(compare_value0))
        else $error("same-value write not filtered");

    a_ch1_filter_same: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch1_wr and (filt_r && !mode_r[MODE_IN1_BIT] && merged == chan1_value)
        |=> $stable(chan1_value) && $stable(compare_value1))
        else $error("channel 1 same-value write not filtered");

    a_cfg_readback: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready_r && !pwrite && sel_cfg && !pslverr_r
        |-> prdata_r[CFG_FILT_BIT] == filt_r && prdata_r[0] == 1'b0)
        else $error("filter bit read back wrong");

    a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_commit && sel_cfg |=> filt_r == $past(merged[CFG_FILT_BIT]))
        else $error("filter bit not written");

    a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_commit && sel_cfg) |=> $stable(filt_r))
        else $error("filter bit changed without a write");

    a_half_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch0_wr and (pstrb == STRB_HALF && !mode_r[MODE_IN0_BIT] && !filt_r)
        |=> chan0_value == $past(pwdata[VAL_W-1:0]))
        else $error("half-word write lost");

    a_ch1_half_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_ch1_wr and (pstrb == STRB_HALF && !mode_r[MODE_IN1_BIT] && !filt_r)
        |=> chan1_value == $past(pwdata[VAL_W-1:0]))
        else $error("channel 1 half-word write lost");

    a_reset_zero: assert property (@(posedge pclk)
        $rose(presetn) |-> chan0_value == RST_VAL && chan1_value == RST_VAL && !filt_r)
        else $error("registers not zero after reset");

endmodule
